// ---- cdbc_clkout.v ----
// Clock output generator: one output period per six CPU clock ticks.
// Assumes a one-cycle CPU tick pulse from the divider on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "cdbc_defs.vh"
module cdbc_clkout (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Control
    input wire cpu_tick,
    input wire enable,
    // Output
    output reg clk_out
);
    reg [2:0] cnt_r; // Ticks within one output period
    // Half high, half low; keeps running in idle as long as ticks arrive
    always @(posedge mclk) begin
        if (!nrst || !enable) begin
            cnt_r <= 3'h0;
            clk_out <= 1'b0;
        end else if (cpu_tick) begin
            if (cnt_r == `CDBC_CLKOUT_DIV - 3'h1) begin
                cnt_r <= 3'h0;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
            clk_out <= (cnt_r < (`CDBC_CLKOUT_DIV >> 1));
        end
    end
endmodule // cdbc_clkout
`default_nettype wire

// ---- cdbc_defs.vh ----
// Constants for the clock divider and brownout control block.
// Assumes inclusion by bare name from the block's design files.
`ifndef CDBC_DEFS_VH
`define CDBC_DEFS_VH
// Register addresses (word index on the plain register port)
`define CDBC_ADDR_CPU_CLOCK_DIVIDER_REG 4'h0
`define CDBC_ADDR_AUX 4'h1
`define CDBC_ADDR_PORT2_MODE_REG1 4'h2
`define CDBC_ADDR_IRQ_ENABLE_REG0 4'h3
`define CDBC_ADDR_POWER_CONTROL_REG 4'h4
`define CDBC_ADDR_STAT 4'h5
// Field positions
`define CDBC_AUX_BOI 5
`define CDBC_AUX_BOD 6
`define CDBC_PORT2_MODE_REG1_CLOCK_OUT_ENABLE 6
`define CDBC_IRQ_ENABLE_REG0_EBO 5
`define CDBC_IRQ_ENABLE_REG0_EA 7
`define CDBC_POWER_CONTROL_REG_BOF 5
// Reset values
`define CDBC_RST_CPU_CLOCK_DIVIDER_REG 8'h00
`define CDBC_RST_AUX 8'h00
`define CDBC_RST_PORT2_MODE_REG1 8'h00
`define CDBC_RST_IRQ_ENABLE_REG0 8'h00
`define CDBC_RST_POWER_CONTROL_REG 8'h00
// Oscillator type codes from non-volatile configuration
`define CDBC_OSC_LF 3'h0
`define CDBC_OSC_MF 3'h1
`define CDBC_OSC_HF 3'h2
`define CDBC_OSC_RC 3'h3
`define CDBC_OSC_EXT 3'h4
// Nominal RC oscillator rate in MHz
`define CDBC_RC_MHZ 6
// Oscillator restart waits in CPU clocks
`define CDBC_WAIT_XTAL 11'h400
`define CDBC_WAIT_RC 11'h100
// Clock output ratio: CPU clocks per output period
`define CDBC_CLKOUT_DIV 3'h6
`endif

// ---- cdbc_sync.v ----
// Two-flop synchroniser for one asynchronous level.
// Assumes the input comes from outside the mclk domain.
`timescale 1ns/1ns
`default_nettype none
module cdbc_sync (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Level in and out
    input wire din,
    output wire dout
);
    reg meta_r; // First stage, read only by stage two
    reg sync_r; // Second stage
    // Two stages; reset to the idle level
    always @(posedge mclk) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end
    assign dout = sync_r;
endmodule // cdbc_sync
`default_nettype wire

// ---- cdbc_top.v ----
// Clock source selection, CPU clock divider, clock output and brownout
// supervision. mclk stands for the selected oscillator clock; the CPU
// clock is expressed as a one-cycle tick enable for the core.
// Assumes cfg_* inputs are static non-volatile configuration values.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "cdbc_defs.vh"
module cdbc_top #(
    parameter DIV_W = 8 // Divider register width
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Non-volatile configuration
    input wire [2:0] cfg_osc_type,
    input wire cfg_compat_half,
    input wire cfg_brownout_level,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Analog brownout comparator
    input wire bo_cmp_low,
    output wire bo_level_high,
    output wire bo_det_enable,
    // Oscillator restart request
    input wire osc_restart,
    // CPU and peripheral timing
    output wire cpu_tick,
    output wire periph_tick,
    output wire cpu_run,
    // Brownout outputs
    output wire cpu_reset_hold,
    output reg bo_irq,
    // Oscillator pins
    input wire osc_in_pin,
    output wire osc_in_gpio_en,
    output wire osc_out_pin,
    output wire osc_out_oe,
    input wire osc_out_gpio_out,
    input wire osc_out_gpio_oe,
    output wire osc_out_gpio_en
);
    // Computes the CPU clock period in oscillator cycles minus one
    function [9:0] cdbc_period;
        input [7:0] n;
        input half;
        begin
            if (n == 8'h00) begin
                cdbc_period = half ? 10'h001 : 10'h000;
            end else begin
                cdbc_period = {1'b0, n, 1'b1};
            end
        end
    endfunction

    // Software registers
    reg [DIV_W-1:0] cpu_clock_divider_reg_r; // Programmable divider
    reg [7:0] aux_control_reg_r; // Brownout select and disable
    reg [7:0] port2_mode_reg1_r; // Clock output enable bit
    reg [7:0] irq_enable_reg0_r; // Global and brownout enables
    reg brownout_flag_r; // Sticky brownout flag
    // Divider state
    reg [9:0] div_cnt_r; // Oscillator cycles in current CPU clock
    reg [10:0] wait_cnt_r; // Restart wait counter
    reg run_r; // Oscillator deemed stable
    reg bo_prev_r; // Previous detector active level (bo_active)
    // Decoded configuration
    wire osc_xtal; // Any crystal option
    wire osc_rc; // On-chip RC option
    wire osc_ext; // External clock option
    wire clkout_allowed; // Output legal for this option
    wire clock_out_enable; // Effective output enable
    wire brownout_irq_select;
    wire brownout_disable;
    wire global_irq_enable;
    wire brownout_irq_enable;
    wire bo_sync; // Synchronised detector level
    wire bo_active; // Detector active and enabled
    wire bo_rise; // Inactive to active transition
    wire [9:0] period; // Current CPU clock period minus one
    wire div_tick; // Divider terminal count
    wire clk_sq; // Clock output waveform

    // Oscillator type taken only from configuration inputs
    assign osc_xtal = (cfg_osc_type == `CDBC_OSC_LF) ||
        (cfg_osc_type == `CDBC_OSC_MF) ||
        (cfg_osc_type == `CDBC_OSC_HF);
    assign osc_rc = (cfg_osc_type == `CDBC_OSC_RC);
    assign osc_ext = (cfg_osc_type == `CDBC_OSC_EXT);
    assign clkout_allowed = osc_rc || osc_ext;
    assign clock_out_enable = clkout_allowed &&
        port2_mode_reg1_r[`CDBC_PORT2_MODE_REG1_CLOCK_OUT_ENABLE];
    assign brownout_irq_select = aux_control_reg_r[`CDBC_AUX_BOI];
    assign brownout_disable = aux_control_reg_r[`CDBC_AUX_BOD];
    assign global_irq_enable = irq_enable_reg0_r[`CDBC_IRQ_ENABLE_REG0_EA];
    assign brownout_irq_enable = irq_enable_reg0_r[`CDBC_IRQ_ENABLE_REG0_EBO];

    // Register writes; divider changes take effect at once
    always @(posedge mclk) begin
        if (!nrst) begin
            cpu_clock_divider_reg_r <= `CDBC_RST_CPU_CLOCK_DIVIDER_REG;
            aux_control_reg_r <= `CDBC_RST_AUX;
            port2_mode_reg1_r <= `CDBC_RST_PORT2_MODE_REG1;
            irq_enable_reg0_r <= `CDBC_RST_IRQ_ENABLE_REG0;
        end else if (reg_wr) begin
            case (reg_addr)
                `CDBC_ADDR_CPU_CLOCK_DIVIDER_REG: begin
                    cpu_clock_divider_reg_r <= reg_wdata;
                end
                `CDBC_ADDR_AUX: begin
                    aux_control_reg_r <= reg_wdata;
                end
                `CDBC_ADDR_PORT2_MODE_REG1: begin
                    port2_mode_reg1_r <= reg_wdata;
                end
                `CDBC_ADDR_IRQ_ENABLE_REG0: begin
                    irq_enable_reg0_r <= reg_wdata;
                end
                default: begin
                    // Other addresses ignore writes, except address 4 clearing the sticky flag
                end
            endcase
        end
    end

    // Sticky flag: a new activation beats a software clear
    always @(posedge mclk) begin
        if (!nrst) begin
            brownout_flag_r <= 1'b0;
        end else if (bo_rise) begin
            brownout_flag_r <= 1'b1;
        end else if (reg_wr && reg_addr == `CDBC_ADDR_POWER_CONTROL_REG &&
                     !reg_wdata[`CDBC_POWER_CONTROL_REG_BOF]) begin
            brownout_flag_r <= 1'b0;
        end
    end

    // Read data one cycle after the read strobe, zero otherwise
    always @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CDBC_ADDR_CPU_CLOCK_DIVIDER_REG: reg_rdata <= cpu_clock_divider_reg_r;
                `CDBC_ADDR_AUX: reg_rdata <= aux_control_reg_r;
                `CDBC_ADDR_PORT2_MODE_REG1: reg_rdata <= port2_mode_reg1_r;
                `CDBC_ADDR_IRQ_ENABLE_REG0: reg_rdata <= irq_enable_reg0_r;
                `CDBC_ADDR_POWER_CONTROL_REG: begin
                    reg_rdata <= {2'h0, brownout_flag_r, 5'h00};
                end
                `CDBC_ADDR_STAT: begin
                    reg_rdata <= {3'h0, bo_active, run_r,
                                  cfg_osc_type};
                end
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // CPU clock divider; period reread every cycle, >= compare so no stall occurs
    assign period = cdbc_period(cpu_clock_divider_reg_r,
                                cfg_compat_half);
    assign div_tick = (div_cnt_r >= period);
    always @(posedge mclk) begin
        if (!nrst) begin
            div_cnt_r <= 10'h000;
        end else if (div_tick) begin
            div_cnt_r <= 10'h000;
        end else begin
            div_cnt_r <= div_cnt_r + 10'h001;
        end
    end
    // Timers and core share one tick, so halving reaches both
    assign cpu_tick = div_tick;
    assign periph_tick = div_tick;

    // Oscillator restart wait counted in CPU clocks
    always @(posedge mclk) begin
        if (!nrst || osc_restart) begin
            run_r <= 1'b0;
            wait_cnt_r <= osc_xtal ? `CDBC_WAIT_XTAL :
                `CDBC_WAIT_RC;
        end else if (!run_r && div_tick) begin
            if (wait_cnt_r == 11'h001) begin
                run_r <= 1'b1;
            end
            wait_cnt_r <= wait_cnt_r - 11'h001;
        end
    end
    assign cpu_run = run_r;

    // Clock output generator
    cdbc_clkout u_clkout (
        .mclk(mclk),
        .nrst(nrst),
        .cpu_tick(div_tick),
        .enable(clock_out_enable),
        .clk_out(clk_sq)
    );

    // Pin sharing; crystal options take both pins away
    assign osc_in_gpio_en = 1'b0;
    assign osc_out_gpio_en = osc_ext && !clock_out_enable;
    assign osc_out_pin = clock_out_enable ? clk_sq :
        (osc_out_gpio_en ? osc_out_gpio_out : 1'b0);
    assign osc_out_oe = clock_out_enable ||
        (osc_out_gpio_en && osc_out_gpio_oe);

    // Threshold and detector enable to the analog part
    assign bo_level_high = !cfg_brownout_level;
    assign bo_det_enable = !brownout_disable;

    // Detector is asynchronous, so synchronise before edge detect
    cdbc_sync u_bo_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(bo_cmp_low),
        .dout(bo_sync)
    );
    assign bo_active = bo_sync && !brownout_disable;
    assign bo_rise = bo_active && !bo_prev_r;

    // Edge memory for one-shot interrupt
    always @(posedge mclk) begin
        if (!nrst) begin
            bo_prev_r <= 1'b0;
        end else begin
            bo_prev_r <= bo_active;
        end
    end

    // Reset by default; held for as long as the detector stays active
    assign cpu_reset_hold = bo_active && !brownout_irq_select;

    // One-cycle interrupt, gated by both enables
    always @(posedge mclk) begin
        if (!nrst) begin
            bo_irq <= 1'b0;
        end else begin
            bo_irq <= bo_rise && brownout_irq_select &&
                global_irq_enable && brownout_irq_enable;
        end
    end
    // Selection between reset and interrupt
    // is brownout_irq_select above
    // (osc_in_pin is the external clock; mclk stands for it)
    wire unused_pin;
    assign unused_pin = osc_in_pin;
endmodule // cdbc_top
`default_nettype wire

// ---- cdbc_top_chk.sv ----
// Assertion checker for the clock divider and brownout block.
// Assumes binding to cdbc_top; it sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module cdbc_top_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Configuration
    input wire logic [2:0] cfg_osc_type,
    input wire logic cfg_compat_half,
    input wire logic cfg_brownout_level,
    // Brownout
    input wire logic bo_cmp_low,
    input wire logic bo_level_high,
    input wire logic bo_det_enable,
    input wire logic cpu_reset_hold,
    input wire logic bo_irq,
    // Timing and pins
    input wire logic cpu_tick,
    input wire logic periph_tick,
    input wire logic osc_out_pin,
    input wire logic osc_out_oe,
    input wire logic osc_out_gpio_oe,
    input wire logic osc_in_gpio_en,
    input wire logic osc_out_gpio_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [3:0] ticks_r; // Ticks seen in current output phase
    logic last_r; // Output level at previous edge
    logic valid_r; // A phase edge was seen under enable, so the current phase is whole
    // Phase tick counter; first phase after enable is skipped
    always_ff @(posedge mclk) begin
        last_r <= osc_out_pin;
        // Port use of the pin is not a clock output phase
        if (!nrst || !osc_out_oe || osc_out_gpio_en) begin
            ticks_r <= 4'h0;
            valid_r <= 1'b0;
        end else if (osc_out_pin != last_r) begin
            ticks_r <= {3'h0, cpu_tick};
            valid_r <= 1'b1;
        end else if (cpu_tick) begin
            ticks_r <= ticks_r + 4'h1;
        end
    end
    AST_LEVEL: assert property (bo_level_high == !cfg_brownout_level)
        else $error("brownout level output wrong");
    AST_IRQ_ONE: assert property (bo_irq |=> !bo_irq)
        else $error("brownout interrupt longer than one cycle");
    AST_IRQ_CAUSE: assert property (bo_irq |-> $past(bo_cmp_low, 3))
        else $error("brownout interrupt without low supply");
    AST_HOLD: assert property (cpu_reset_hold |->
        bo_det_enable && $past(bo_cmp_low, 2))
        else $error("reset hold without active detector");
    AST_XTAL: assert property ((cfg_osc_type < 3'h3) |->
        !osc_in_gpio_en && !osc_out_gpio_en && !osc_out_oe)
        else $error("oscillator pin used in crystal mode");
    AST_PERIPH: assert property (periph_tick == cpu_tick)
        else $error("peripheral tick differs from cpu tick");
    AST_HALF: assert property (cfg_compat_half && cpu_tick |=> !cpu_tick)
        else $error("halved clock ticks twice in a row");
    AST_CLKOUT: assert property (valid_r && osc_out_pin != last_r
        |-> ticks_r == 4'h3)
        else $error("clock output phase not three ticks");
    AST_EXT: assert property ((cfg_osc_type == 3'h4) |->
        (osc_out_gpio_en ? (osc_out_oe == osc_out_gpio_oe) : osc_out_oe))
        else $error("second pin not free in external mode");
    COV_IRQ: cover property (bo_irq);
    COV_HOLD: cover property (cpu_reset_hold);
    COV_CLKOUT: cover property (valid_r && osc_out_pin != last_r);
endmodule // cdbc_top_chk
bind cdbc_top cdbc_top_chk i_chk (.*);
`default_nettype wire

// ---- cdbc_top_test.sv ----
// Self-checking bench for the clock divider and brownout block.
// Assumes cdbc_top and its checker are compiled beforehand.
`timescale 1ns/1ns
`default_nettype none
module cdbc_top_test;
    logic mclk, nrst, cfg_compat_half, cfg_brownout_level;
    logic [2:0] cfg_osc_type;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, bo_cmp_low, bo_level_high, bo_det_enable;
    logic osc_restart, cpu_tick, periph_tick, cpu_run, cpu_reset_hold;
    logic bo_irq, osc_in_pin, osc_in_gpio_en, osc_out_pin, osc_out_oe;
    logic osc_out_gpio_out, osc_out_gpio_oe, osc_out_gpio_en;
    logic [9:0] p, h; // Measured period, pulses, hold
    int fail_count = 0;
    int total_checks = 0;
    // Divider value (top byte) beside expected tick period, ends included
    logic [17:0] rows [4] = '{{8'h00, 10'h001}, {8'h01, 10'h004},
        {8'h03, 10'h008}, {8'hFF, 10'h200}};
    cdbc_top i_dut (.*);
    // Free-running 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [9:0] e,
        input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %0h got %0h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("reg_rdata", {2'b0, e}, {2'b0, reg_rdata});
    endtask
    task automatic reset_dut(input logic [2:0] osc, input logic half);
        @(posedge mclk);
        nrst <= 1'b0;
        cfg_osc_type <= osc;
        cfg_compat_half <= half;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
    endtask
    // Cycles from one cpu tick to the next, bounded
    task automatic period(output logic [9:0] q);
        int n;
        @(negedge mclk);
        for (n = 0; n < 600 && cpu_tick !== 1'b1; n++) @(negedge mclk);
        q = 10'h0;
        do begin
            @(negedge mclk);
            q++;
        end while (cpu_tick !== 1'b1 && q < 10'h3FF);
    endtask
    // Supply dips for twelve cycles, then recovers
    task automatic bo_cycle(output logic [9:0] pulses,
        output logic [9:0] held);
        pulses = 10'h0;
        @(posedge mclk);
        bo_cmp_low <= 1'b1;
        repeat (12) begin
            @(negedge mclk);
            if (bo_irq === 1'b1) pulses++;
        end
        held = {9'h0, cpu_reset_hold};
        @(posedge mclk);
        bo_cmp_low <= 1'b0;
        repeat (6) @(negedge mclk);
        chk("hold_release", 10'h0, {9'h0, cpu_reset_hold});
    endtask
    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well beyond the expected run
    initial begin
        #(100 * 20000);
        fail_count++;
        finish_test;
    end
    initial begin
        {nrst, cfg_compat_half, reg_wr, reg_rd, bo_cmp_low} = 5'h00;
        {osc_restart, osc_in_pin, osc_out_gpio_out, osc_out_gpio_oe} = 4'h0;
        cfg_osc_type = 3'h3;
        cfg_brownout_level = 1'b1;
        {reg_addr, reg_wdata} = 12'h000;
        reset_dut(3'h3, 1'b0);
        repeat (250) @(negedge mclk);
        chk("cpu_run_early", 10'h0, {9'h0, cpu_run});
        repeat (10) @(negedge mclk);
        chk("cpu_run_late", 10'h1, {9'h0, cpu_run});
        for (int a = 0; a < 5; a++) rd_chk(a[3:0], 8'h00);
        wr(4'h5, 8'hFF);
        rd_chk(4'h5, 8'h0B);
        rd_chk(4'hF, 8'h00);
        foreach (rows[i]) begin
            wr(4'h0, rows[i][17:10]);
            rd_chk(4'h0, rows[i][17:10]);
            period(p);
            period(p);
            chk("tick_period", rows[i][9:0], p);
        end
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h40);
        rd_chk(4'h2, 8'h40);
        repeat (30) @(negedge mclk);
        chk("clkout_oe", 10'h1, {9'h0, osc_out_oe});
        // One tick per cycle: twelve cycles hold six high ones
        h = 10'h0;
        repeat (12) begin
            @(negedge mclk);
            if (osc_out_pin === 1'b1) h++;
        end
        chk("clkout_high", 10'h6, h);
        bo_cycle(p, h);
        chk("irq_pulses", 10'h0, p);
        chk("reset_hold", 10'h1, h);
        rd_chk(4'h4, 8'h20);
        wr(4'h4, 8'h00);
        rd_chk(4'h4, 8'h00);
        wr(4'h1, 8'h20);
        wr(4'h3, 8'hA0);
        bo_cycle(p, h);
        chk("irq_pulses", 10'h1, p);
        chk("reset_hold", 10'h0, h);
        wr(4'h3, 8'h80);
        bo_cycle(p, h);
        chk("irq_masked", 10'h0, p);
        rd_chk(4'h4, 8'h20);
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h60);
        bo_cycle(p, h);
        chk("irq_disabled", 10'h0, p + h);
        rd_chk(4'h4, 8'h00);
        chk("det_enable", 10'h0, {9'h0, bo_det_enable});
        @(posedge mclk);
        cfg_brownout_level <= 1'b0;
        reset_dut(3'h0, 1'b0);
        wr(4'h2, 8'h40);
        repeat (20) @(negedge mclk);
        chk("xtal_oe", 10'h0, {9'h0, osc_out_oe});
        chk("xtal_gpio", 10'h0, {9'h0, osc_out_gpio_en});
        chk("level_high", 10'h1, {9'h0, bo_level_high});
        // Crystal restart wait is 1024 ticks of one cycle each
        repeat (990) @(negedge mclk);
        chk("xtal_run_early", 10'h0, {9'h0, cpu_run});
        repeat (20) @(negedge mclk);
        chk("xtal_run_late", 10'h1, {9'h0, cpu_run});
        reset_dut(3'h4, 1'b1);
        @(negedge mclk);
        chk("ext_gpio", 10'h1, {9'h0, osc_out_gpio_en});
        period(p);
        period(p);
        chk("half_period", 10'h2, p);
        chk("in_gpio", 10'h0, {9'h0, osc_in_gpio_en});
        // Second pin passes the port value through
        @(posedge mclk);
        osc_out_gpio_oe <= 1'b1;
        osc_out_gpio_out <= 1'b1;
        @(negedge mclk);
        chk("gpio_pin", 10'h1, {9'h0, osc_out_pin});
        chk("gpio_oe", 10'h1, {9'h0, osc_out_oe});
        repeat (520) @(negedge mclk);
        chk("ext_run", 10'h1, {9'h0, cpu_run});
        // Restart: 256 ticks of two cycles each
        @(posedge mclk);
        osc_restart <= 1'b1;
        @(posedge mclk);
        osc_restart <= 1'b0;
        @(negedge mclk);
        chk("restart_run", 10'h0, {9'h0, cpu_run});
        repeat (500) @(negedge mclk);
        chk("restart_early", 10'h0, {9'h0, cpu_run});
        repeat (20) @(negedge mclk);
        chk("restart_late", 10'h1, {9'h0, cpu_run});
        finish_test;
    end
endmodule // cdbc_top_test
`default_nettype wire
